// ===== hw/otps_pkg.sv
// Purpose: constants for the tile fuse memory, protection word and scan port
// Assumes: one tile, fuse rows are 32 bits, scan pins arrive unsynchronised
package otps_pkg;
   // fuse array geometry
   localparam int SECTORS = 4;
   localparam int SECTOR_ROWS = 512;
   localparam int ROWS = SECTORS * SECTOR_ROWS;
   localparam int RED_ROWS = 16;
   localparam int SRAM_WORDS = 32768;
   // programming port resource numbers
   localparam logic [23:0] RES_ADDR_PORT = 24'h100200;
   localparam logic [23:0] RES_DATA_PORT = 24'h200100;
   localparam logic [23:0] RES_CTRL_PORT = 24'h100300;
   // control port fields
   localparam int CTRL_GO = 0;
   localparam int CTRL_SEC = 1;
   // address port fields
   localparam int ADDR_RED = 11;
   // protection word bit positions
   localparam int SEC_NO_SCAN = 0;
   localparam int SEC_NO_LINK = 1;
   localparam int SEC_BOOT_OTP = 5;
   localparam int SEC_REDUNDANT = 7;
   localparam int SEC_LOCK0 = 8;
   localparam int SEC_MASTER = 12;
   localparam int SEC_NO_SCAN_OTP = 13;
   localparam int SEC_NO_DEBUG = 14;
   localparam int SEC_GP_LO = 15;
   localparam int SEC_GP_HI = 21;
   localparam int SEC_UID_LO = 22;
   localparam int SEC_UID_HI = 31;
   localparam logic [31:0] SEC_RESET = 32'h0000_0000;
   // scan instruction codes
   localparam logic [3:0] IR_SCAN_IDENTIFICATION_WORD = 4'h1;
   localparam logic [3:0] IR_USERCODE = 4'h2;
   localparam logic [3:0] IR_CHIP = 4'h3;
   localparam logic [3:0] IR_OTP_ADDR = 4'h8;
   localparam logic [3:0] IR_OTP_WRITE = 4'h9;
   localparam logic [3:0] IR_BYPASS = 4'hf;
   localparam logic [3:0] IR_CAPTURE = 4'h1;
   // identification fields, values arbitrary
   localparam logic [3:0] ID_VERSION = 4'h0;
   localparam logic [15:0] ID_PART = 16'h1234;
   localparam logic [10:0] ID_MAKER = 11'h155;
   localparam logic [11:0] SILICON_REV = 12'h001;
   // minimum test reset time
   localparam int TRST_MIN_NS = 100;
   localparam int CLK_NS = 25;
   localparam int TRST_MIN_CYC = (TRST_MIN_NS + CLK_NS - 1) / CLK_NS;
endpackage

// ===== hw/otps_top.sv
// Purpose: tile fuse memory with protection word, scan port and SRAM
// Assumes: scan and debug pins are asynchronous to clk_sys
// Notes: fuse contents survive rstn; only power-on blank state is zero
`timescale 1ns/1ps
module otps_top
(
   input wire logic clk_sys,
   input wire logic rstn,
   // programming ports from the processor
   input wire logic [15:0] prog_addr,
   input wire logic [31:0] prog_data,
   input wire logic [15:0] prog_ctrl,
   output logic prog_done,
   output logic prog_err,
   // sram access from the processor
   input wire logic cpu_req,
   input wire logic cpu_we,
   input wire logic [3:0] cpu_be,
   input wire logic [14:0] cpu_addr,
   input wire logic [31:0] cpu_wdata,
   output logic [31:0] cpu_rdata,
   output logic cpu_ack,
   // boot and protection status
   output logic boot_ready,
   output logic boot_from_otp,
   output logic [31:0] protection_word,
   output logic [6:0] gp_field,
   output logic redundant_en,
   // switch access from other tiles
   input wire logic link_req,
   output logic link_grant,
   // scan port pins
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic trst_n,
   output logic tdo,
   output logic tdo_oe,
   // chained chip port
   output logic chip_tdi,
   output logic chip_tms,
   output logic chip_sel,
   input wire logic chip_tdo,
   // debug sync pin
   input wire logic dbg_out_mode,
   input wire logic dbg_in_mode,
   input wire logic breakpoint_hit,
   input wire logic debug_in,
   output logic debug_out,
   output logic debug_oe,
   output logic debug_req
);
   typedef enum logic [1:0]
   {
      BOOT_LOAD = 2'b00,
      BOOT_COPY = 2'b01,
      BOOT_RUN = 2'b10
   } otps_boot_t;

   typedef enum logic [3:0]
   {
      TAP_RESET = 4'b0000,
      TAP_IDLE = 4'b0001,
      TAP_SEL_DR = 4'b0010,
      TAP_CAP_DR = 4'b0011,
      TAP_SH_DR = 4'b0100,
      TAP_EX1_DR = 4'b0101,
      TAP_PA_DR = 4'b0110,
      TAP_EX2_DR = 4'b0111,
      TAP_UP_DR = 4'b1000,
      TAP_SEL_IR = 4'b1001,
      TAP_CAP_IR = 4'b1010,
      TAP_SH_IR = 4'b1011,
      TAP_EX1_IR = 4'b1100,
      TAP_PA_IR = 4'b1101,
      TAP_EX2_IR = 4'b1110,
      TAP_UP_IR = 4'b1111
   } otps_tap_t;

   ////////////////////////////////////////////////////////////////////////////
   // fuse storage: main sectors, redundant rows, protection word

   logic [31:0] fuse [0:otps_pkg::ROWS-1];
   logic [31:0] fuse_red [0:otps_pkg::RED_ROWS-1];
   logic [31:0] fuse_sec;
   logic [31:0] sram [0:otps_pkg::SRAM_WORDS-1];

   // blank fuses read as zero at power-on
   initial
   begin
      for (int i = 0; i < otps_pkg::ROWS; i++)
         fuse[i] = 32'h0000_0000;
      for (int i = 0; i < otps_pkg::RED_ROWS; i++)
         fuse_red[i] = 32'h0000_0000;
      fuse_sec = 32'h0000_0000;
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [4:0] sync1;
   logic [4:0] sync2;
   logic tck_prev;

   // two flops on the scan pins and debug_in only
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         sync1 <= 5'h00;
         sync2 <= 5'h00;
         tck_prev <= 1'b0;
      end
      else
      begin
         sync1 <= {debug_in, trst_n, tdi, tms, tck};
         sync2 <= sync1;
         tck_prev <= sync2[0];
      end
   end

   wire tck_s = sync2[0];
   wire tms_s = sync2[1];
   wire tdi_s = sync2[2];
   wire trst_s = sync2[3];
   wire debug_in_s = sync2[4];
   wire tck_rise = tck_s & ~tck_prev;
   wire tck_fall = ~tck_s & tck_prev;

   ////////////////////////////////////////////////////////////////////////////
   // boot sequence: load protection word, then copy fuses to sram

   otps_boot_t boot_st;
   logic [10:0] copy_idx;
   logic [31:0] prot;

   // power-up load and copy
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         boot_st <= BOOT_LOAD;
         copy_idx <= 11'h000;
         prot <= otps_pkg::SEC_RESET;
      end
      else
      begin
         case (boot_st)
            BOOT_LOAD:
            begin
               prot <= fuse_sec;
               boot_st <= BOOT_COPY;
            end
            BOOT_COPY:
            begin
               copy_idx <= copy_idx + 11'h001;
               if (copy_idx == 11'(otps_pkg::ROWS - 1))
                  boot_st <= BOOT_RUN;
            end
            BOOT_RUN:
               boot_st <= BOOT_RUN;
            default:
               boot_st <= BOOT_LOAD;
         endcase
      end
   end

   wire copying = (boot_st == BOOT_COPY);

   ////////////////////////////////////////////////////////////////////////////
   // protection decode

   wire no_scan = prot[otps_pkg::SEC_NO_SCAN];
   wire no_link = prot[otps_pkg::SEC_NO_LINK];
   wire red_on = prot[otps_pkg::SEC_REDUNDANT];
   wire master_lock = prot[otps_pkg::SEC_MASTER];
   wire no_scan_otp = prot[otps_pkg::SEC_NO_SCAN_OTP] | no_scan;
   wire no_debug = prot[otps_pkg::SEC_NO_DEBUG];
   wire [3:0] sector_lock = prot[otps_pkg::SEC_LOCK0 +: otps_pkg::SECTORS];

   ////////////////////////////////////////////////////////////////////////////
   // scan tap state machine, advanced on tck rising edges

   otps_tap_t tap_st;
   otps_tap_t next_tap_st;
   logic [3:0] ir;
   logic [3:0] ir_sh;
   logic [31:0] dr;
   logic [10:0] scan_addr;
   logic scan_red;
   logic scan_wr_req;
   wire prog_go;

   // standard tap transitions
   always_comb
   begin
      next_tap_st = tap_st;
      case (tap_st)
         TAP_RESET: next_tap_st = tms_s ? TAP_RESET : TAP_IDLE;
         TAP_IDLE: next_tap_st = tms_s ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: next_tap_st = tms_s ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: next_tap_st = tms_s ? TAP_EX1_DR : TAP_SH_DR;
         TAP_SH_DR: next_tap_st = tms_s ? TAP_EX1_DR : TAP_SH_DR;
         TAP_EX1_DR: next_tap_st = tms_s ? TAP_UP_DR : TAP_PA_DR;
         TAP_PA_DR: next_tap_st = tms_s ? TAP_EX2_DR : TAP_PA_DR;
         TAP_EX2_DR: next_tap_st = tms_s ? TAP_UP_DR : TAP_SH_DR;
         TAP_UP_DR: next_tap_st = tms_s ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: next_tap_st = tms_s ? TAP_RESET : TAP_CAP_IR;
         TAP_CAP_IR: next_tap_st = tms_s ? TAP_EX1_IR : TAP_SH_IR;
         TAP_SH_IR: next_tap_st = tms_s ? TAP_EX1_IR : TAP_SH_IR;
         TAP_EX1_IR: next_tap_st = tms_s ? TAP_UP_IR : TAP_PA_IR;
         TAP_PA_IR: next_tap_st = tms_s ? TAP_EX2_IR : TAP_PA_IR;
         TAP_EX2_IR: next_tap_st = tms_s ? TAP_UP_IR : TAP_SH_IR;
         TAP_UP_IR: next_tap_st = tms_s ? TAP_SEL_DR : TAP_IDLE;
         default: next_tap_st = TAP_RESET;
      endcase
   end

   // capture values for the data register
   wire [31:0] id_word = {otps_pkg::ID_VERSION, otps_pkg::ID_PART, otps_pkg::ID_MAKER,
      1'b1};
   wire [31:0] user_word = {prot[otps_pkg::SEC_UID_HI:otps_pkg::SEC_UID_LO], 10'h000,
      otps_pkg::SILICON_REV};
   wire [31:0] scan_rd = scan_red ? fuse_red[scan_addr[3:0]] : fuse[scan_addr];
   wire [31:0] otp_cap = no_scan_otp ? 32'h0000_0000 : scan_rd;
   wire chip_path = (ir == otps_pkg::IR_CHIP) & ~no_scan;
   wire bypass_path = ~((ir == otps_pkg::IR_SCAN_IDENTIFICATION_WORD) | (ir == otps_pkg::IR_USERCODE) |
      (ir == otps_pkg::IR_OTP_ADDR) | (ir == otps_pkg::IR_OTP_WRITE));
   wire [31:0] dr_cap = (ir == otps_pkg::IR_SCAN_IDENTIFICATION_WORD) ? id_word :
      (ir == otps_pkg::IR_USERCODE) ? user_word :
      (ir == otps_pkg::IR_OTP_ADDR) ? otp_cap : 32'h0000_0000;
   wire [31:0] dr_shift = bypass_path ? {dr[31:1], tdi_s} : {tdi_s, dr[31:1]};
   wire dr_out = bypass_path ? dr[0] : dr[0];
   wire scan_out = tap_st == TAP_SH_IR ? ir_sh[0] : (chip_path ? chip_tdo : dr_out);
   wire scan_shift = (tap_st == TAP_SH_IR) | (tap_st == TAP_SH_DR);

   // tap state, ir and scan write request, held in reset while test reset is low
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         tap_st <= TAP_RESET;
         ir <= otps_pkg::IR_SCAN_IDENTIFICATION_WORD;
         ir_sh <= 4'h0;
         dr <= 32'h0000_0000;
         scan_addr <= 11'h000;
         scan_red <= 1'b0;
         scan_wr_req <= 1'b0;
      end
      else if (!trst_s)
      begin
         tap_st <= TAP_RESET;
         ir <= otps_pkg::IR_SCAN_IDENTIFICATION_WORD;
         scan_wr_req <= 1'b0;
      end
      else if (tck_rise)
      begin
         tap_st <= next_tap_st;
         if (tap_st == TAP_RESET)
            ir <= otps_pkg::IR_SCAN_IDENTIFICATION_WORD;
         if (tap_st == TAP_CAP_IR)
            ir_sh <= otps_pkg::IR_CAPTURE;
         if (tap_st == TAP_SH_IR)
            ir_sh <= {tdi_s, ir_sh[3:1]};
         if (tap_st == TAP_UP_IR)
            ir <= ir_sh;
         if (tap_st == TAP_CAP_DR)
            dr <= dr_cap;
         if (tap_st == TAP_SH_DR)
            dr <= dr_shift;
         if (tap_st == TAP_UP_DR && ir == otps_pkg::IR_OTP_ADDR && !no_scan_otp)
         begin
            scan_addr <= dr[10:0];
            scan_red <= dr[otps_pkg::ADDR_RED];
         end
         if (tap_st == TAP_UP_DR && ir == otps_pkg::IR_OTP_WRITE)
            scan_wr_req <= ~no_scan_otp;
      end
      else if (scan_wr_req && !prog_go && !copying)
         scan_wr_req <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // fuse programming: processor ports first, scan writes second

   assign prog_go = prog_ctrl[otps_pkg::CTRL_GO] & ~copying;
   wire scan_go = scan_wr_req & ~prog_go & ~copying;
   wire wr_sec = prog_go & prog_ctrl[otps_pkg::CTRL_SEC];
   wire [15:0] wr_addr = prog_go ? prog_addr : {4'h0, scan_red, scan_addr};
   wire [31:0] wr_data = prog_go ? prog_data : dr;
   wire wr_red = wr_addr[otps_pkg::ADDR_RED];
   wire [1:0] wr_sector = wr_addr[10:9];
   wire wr_any = prog_go | scan_go;
   wire wr_bad_range = (|wr_addr[15:12]) | (wr_red & (~red_on | (|wr_addr[10:4])));
   wire wr_denied = master_lock | (~wr_sec & ~wr_red & sector_lock[wr_sector]) |
      (~wr_sec & wr_bad_range);
   wire wr_ok = wr_any & ~wr_denied;

   // bits only ever get set; plain always as the blank state comes from initial
   always @(posedge clk_sys)
   begin
      if (wr_ok && wr_sec)
         fuse_sec <= fuse_sec | wr_data;
      else if (wr_ok && wr_red)
         fuse_red[wr_addr[3:0]] <= fuse_red[wr_addr[3:0]] | wr_data;
      else if (wr_ok)
         fuse[wr_addr[10:0]] <= fuse[wr_addr[10:0]] | wr_data;
   end

   // programming result flags
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         prog_done <= 1'b0;
         prog_err <= 1'b0;
      end
      else
      begin
         prog_done <= wr_ok;
         prog_err <= wr_any & wr_denied;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sram: copy target during boot, then one-cycle processor access

   wire cpu_go = cpu_req & (boot_st == BOOT_RUN);
   wire [31:0] cpu_old = sram[cpu_addr];
   wire [31:0] be_mask = {{8{cpu_be[3]}}, {8{cpu_be[2]}}, {8{cpu_be[1]}}, {8{cpu_be[0]}}};
   wire [31:0] cpu_merge = (cpu_old & ~be_mask) | (cpu_wdata & be_mask);

   // sram write port
   always_ff @(posedge clk_sys)
   begin
      if (copying)
         sram[15'(copy_idx)] <= fuse[copy_idx];
      else if (cpu_go && cpu_we)
         sram[cpu_addr] <= cpu_merge;
   end

   // read data and acknowledge in the next cycle
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         cpu_rdata <= 32'h0000_0000;
         cpu_ack <= 1'b0;
      end
      else
      begin
         cpu_ack <= cpu_go;
         if (cpu_go && !cpu_we)
            cpu_rdata <= cpu_old;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // scan output pins: tdo and tdo_oe updated on tck falling edges, chip pins every clock

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         tdo <= 1'b0;
         tdo_oe <= 1'b0;
         chip_tdi <= 1'b0;
         chip_tms <= 1'b0;
         chip_sel <= 1'b0;
      end
      else
      begin
         if (tck_fall)
         begin
            tdo <= scan_out;
            tdo_oe <= scan_shift;
         end
         chip_sel <= chip_path & trst_s;
         chip_tdi <= chip_path & tdi_s;
         chip_tms <= chip_path & tms_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status outputs, link gate and debug sync pin

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         boot_ready <= 1'b0;
         boot_from_otp <= 1'b0;
         protection_word <= otps_pkg::SEC_RESET;
         gp_field <= 7'h00;
         redundant_en <= 1'b0;
         link_grant <= 1'b0;
         debug_out <= 1'b0;
         debug_oe <= 1'b0;
         debug_req <= 1'b0;
      end
      else
      begin
         boot_ready <= (boot_st == BOOT_RUN);
         boot_from_otp <= prot[otps_pkg::SEC_BOOT_OTP];
         protection_word <= prot;
         gp_field <= prot[otps_pkg::SEC_GP_HI:otps_pkg::SEC_GP_LO];
         redundant_en <= red_on;
         link_grant <= link_req & ~no_link;
         debug_out <= 1'b0;
         debug_oe <= dbg_out_mode & breakpoint_hit & ~no_debug;
         debug_req <= dbg_in_mode & ~debug_in_s & ~no_debug;
      end
   end
endmodule // otps_top

// ===== test/otps_properties.sv
// Purpose: port checks for fuse programming, protection word, sram and debug pin
// Assumes: protection word moves only at the load after reset
// Notes: bound to every otps_top instance
`timescale 1ns/1ps
module otps_properties
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [15:0] prog_addr,
   input wire logic [15:0] prog_ctrl,
   input wire logic prog_done,
   input wire logic prog_err,
   input wire logic cpu_req,
   input wire logic cpu_ack,
   input wire logic boot_ready,
   input wire logic boot_from_otp,
   input wire logic [31:0] protection_word,
   input wire logic [6:0] gp_field,
   input wire logic redundant_en,
   input wire logic link_req,
   input wire logic link_grant,
   input wire logic debug_out,
   input wire logic debug_oe,
   input wire logic debug_req
);
   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);
   wire logic go;
   // a write request that the block must take
   assign go = prog_ctrl[0] && boot_ready;
   //////////////////////////////////////////////////
   // programming answers and refusals
   a_prog_answer: assert property (go |=> prog_done ^ prog_err)
      else $error("go not answered once");
   a_prog_quiet: assert property (!prog_ctrl[0] |=> !prog_done && !prog_err)
      else $error("answer without go");
   a_master_lock: assert property (go && protection_word[12] |=> prog_err)
      else $error("write taken under master lock");
   a_sector_lock: assert property (go && !prog_ctrl[1] && prog_addr[15:11] == 5'h00
      && protection_word[8 + prog_addr[10:9]] |=> prog_err)
      else $error("write taken in locked sector");
   a_red_refuse: assert property (go && !prog_ctrl[1] && prog_addr[11]
      && !protection_word[7] |=> prog_err)
      else $error("redundant row written while disabled");
   // switch access and status fields
   a_link_grant: assert property ($past(rstn) |-> link_grant ==
      ($past(link_req) && !$past(protection_word[1])))
      else $error("link grant wrong");
   a_gp_field: assert property (boot_ready |-> gp_field == protection_word[21:15])
      else $error("gp field differs");
   a_boot_select: assert property (boot_ready |-> boot_from_otp == protection_word[5])
      else $error("boot select differs");
   a_red_enable: assert property (boot_ready |-> redundant_en == protection_word[7])
      else $error("redundant enable differs");
   a_prot_hold: assert property (boot_ready |=> $stable(protection_word))
      else $error("protection word moved");
   // sram handshake
   a_sram_ack: assert property (cpu_req && boot_ready |=> cpu_ack)
      else $error("sram access not acknowledged");
   a_ack_cause: assert property (cpu_ack |-> $past(cpu_req) && $past(boot_ready))
      else $error("ack without request");
   // debug sync pin
   a_debug_off: assert property (boot_ready && protection_word[14]
      |-> !debug_oe && !debug_req)
      else $error("debug pin active while disabled");
   a_debug_low: assert property (debug_oe |-> !debug_out)
      else $error("debug pin driven high");
endmodule // otps_properties

bind otps_top otps_properties chk_u (.clk_sys, .rstn, .prog_addr, .prog_ctrl, .prog_done,
   .prog_err, .cpu_req, .cpu_ack, .boot_ready, .boot_from_otp, .protection_word, .gp_field,
   .redundant_en, .link_req, .link_grant, .debug_out, .debug_oe, .debug_req);

// ===== test/otps_scan_host.sv
// Purpose: scan port host driving the test pins
// Assumes: scan clock period 200 ns, still between frames
// Notes: tdo taken just before each falling edge
`timescale 1ns/1ps
module otps_scan_host
(
   output logic tck,
   output logic tms,
   output logic tdi,
   output logic trst_n,
   input wire logic tdo
);
   logic got;
   // pins idle, test reset low from power-up
   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
      trst_n = 1'b0;
   end
   //////////////////////////////////////////////////
   // one scan clock period
   task automatic step(input logic m, input logic v);
      tms = m;
      tdi = v;
      #100 tck = 1'b1;
      #90 got = tdo;
      #10 tck = 1'b0;
   endtask
   // test reset pulse, then walk to idle
   task automatic scan_reset;
      trst_n = 1'b0;
      #200 trst_n = 1'b1;
      repeat (5) step(1'b1, ~tdi);
      step(1'b0, ~tdi);
   endtask
   // ir or dr scan from idle back to idle, lsb first
   task automatic shift(input logic ir, input int n, input logic [31:0] din,
      output logic [31:0] q);
      q = 32'h0000_0000;
      step(1'b1, ~tdi);
      if (ir)
         step(1'b1, ~tdi);
      step(1'b0, ~tdi);
      step(1'b0, ~tdi);
      for (int i = 0; i < n; i++)
      begin
         step(i == n - 1, din[i]);
         q[i] = got;
      end
      step(1'b1, ~tdi);
      step(1'b0, ~tdi);
   endtask
endmodule // otps_scan_host

// ===== test/otps_top_tb.sv
// Purpose: directed test of fuse programming, protection word, sram and scan port
// Assumes: fuses blank at time zero, survive rstn
// Notes: three boots with growing protection word
`timescale 1ns/1ps
module otps_top_tb;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic [15:0] prog_addr = 16'h0000;
   logic [31:0] prog_data = 32'h0000_0000;
   logic [15:0] prog_ctrl = 16'h0000;
   logic cpu_req = 1'b0;
   logic cpu_we = 1'b0;
   logic [3:0] cpu_be = 4'h0;
   logic [14:0] cpu_addr = 15'h0000;
   logic [31:0] cpu_wdata = 32'h0000_0000;
   logic link_req = 1'b0;
   logic chip_tdo = 1'b0;
   logic dbg_out_mode = 1'b0;
   logic dbg_in_mode = 1'b0;
   logic breakpoint_hit = 1'b0;
   logic ext_dbg_n = 1'b1;
   logic tck, tms, tdi, trst_n, tdo, tdo_oe, chip_tdi, chip_tms, chip_sel, debug_in;
   logic prog_done, prog_err, cpu_ack, boot_ready, boot_from_otp, redundant_en;
   logic debug_out, debug_oe, debug_req, link_grant;
   logic [31:0] cpu_rdata, protection_word, d;
   logic [6:0] gp_field;
   int error_cnt = 0;
   int samples_checked = 0;
   int cyc = 0;
   // debug pin wire with pull-up
   assign debug_in = (debug_oe ? debug_out : 1'b1) & ext_dbg_n;
   always #12.5 clk_sys = ~clk_sys;
   otps_top dut_u (.clk_sys, .rstn, .prog_addr, .prog_data, .prog_ctrl, .prog_done, .prog_err,
      .cpu_req, .cpu_we, .cpu_be, .cpu_addr, .cpu_wdata, .cpu_rdata, .cpu_ack, .boot_ready,
      .boot_from_otp, .protection_word, .gp_field, .redundant_en, .link_req, .link_grant,
      .tck, .tms, .tdi, .trst_n, .tdo, .tdo_oe, .chip_tdi, .chip_tms, .chip_sel, .chip_tdo,
      .dbg_out_mode, .dbg_in_mode, .breakpoint_hit, .debug_in, .debug_out, .debug_oe,
      .debug_req);
   otps_scan_host host_u (.tck, .tms, .tdi, .trst_n, .tdo);
   //////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // reset pulse, wait for load and copy
   task automatic boot;
      @(posedge clk_sys) rstn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      for (int i = 0; i < 3000 && !boot_ready; i++) @(negedge clk_sys);
      chk(boot_ready, 1'b1);
   endtask
   task automatic prog(input logic [15:0] a, input logic [31:0] v, input logic sec,
      input logic err);
      @(posedge clk_sys);
      prog_addr <= a;
      prog_data <= v;
      prog_ctrl <= {14'h0000, sec, 1'b1};
      @(posedge clk_sys) prog_ctrl <= 16'h0000;
      @(negedge clk_sys);
      chk({prog_done, prog_err}, {~err, err});
   endtask
   task automatic cpu(input logic we, input logic [3:0] be, input logic [14:0] a,
      input logic [31:0] v);
      @(posedge clk_sys);
      cpu_req <= 1'b1;
      cpu_we <= we;
      cpu_be <= be;
      cpu_addr <= a;
      cpu_wdata <= v;
      @(posedge clk_sys) cpu_req <= 1'b0;
      @(negedge clk_sys);
      chk(cpu_ack, 1'b1);
      d = cpu_rdata;
   endtask
   task automatic lnk(input logic exp);
      @(posedge clk_sys) link_req <= 1'b1;
      repeat (3) @(negedge clk_sys);
      chk(link_grant, exp);
      @(posedge clk_sys) link_req <= 1'b0;
   endtask
   task automatic scan(input logic [3:0] ir, input logic [31:0] din);
      host_u.shift(1'b1, 4, {28'h0, ir}, d);
      chk(d, 32'h1);
      host_u.shift(1'b0, 32, din, d);
   endtask
   // breakpoint drive, then external low level
   task automatic dbg(input logic on);
      @(posedge clk_sys);
      dbg_out_mode <= 1'b1;
      dbg_in_mode <= 1'b1;
      breakpoint_hit <= 1'b1;
      repeat (6) @(negedge clk_sys);
      chk({debug_oe, debug_out}, {on, 1'b0});
      @(posedge clk_sys);
      breakpoint_hit <= 1'b0;
      ext_dbg_n <= 1'b0;
      repeat (8) @(negedge clk_sys);
      chk({debug_oe, debug_req}, {1'b0, on});
      @(posedge clk_sys) ext_dbg_n <= 1'b1;
   endtask
   //////////////////////////////////////////////////
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         error_cnt++;
         test_done();
      end
   end
   initial
   begin
      boot();
      chk(protection_word, 32'h0);
      cpu(1'b1, 4'hf, 15'h0010, 32'h1234_5678);
      cpu(1'b1, 4'h4, 15'h0010, 32'h00ab_0000);
      cpu(1'b1, 4'h3, 15'h0010, 32'h0000_beef);
      cpu(1'b0, 4'hf, 15'h0010, 32'h0);
      chk(d, 32'h12ab_beef);
      lnk(1'b1);
      host_u.scan_reset();
      host_u.shift(1'b0, 32, 32'h0, d);
      chk(d, {otps_pkg::ID_VERSION, otps_pkg::ID_PART, otps_pkg::ID_MAKER, 1'b1});
      scan(otps_pkg::IR_USERCODE, 32'h0);
      chk(d, {20'h00000, otps_pkg::SILICON_REV});
      dbg(1'b1);
      prog(16'h0200, 32'ha5a5_0f0f, 1'b0, 1'b0);
      prog(16'h0200, 32'h0000_f0f0, 1'b0, 1'b0);
      prog(16'h0800, 32'h0000_0001, 1'b0, 1'b1);
      prog(16'h1000, 32'h0000_0001, 1'b0, 1'b1);
      prog(16'h0000, 32'ha96a_c2a2, 1'b1, 1'b0);
      boot();
      chk(protection_word, 32'ha96a_c2a2);
      chk({gp_field, redundant_en, boot_from_otp}, {7'h55, 1'b1, 1'b1});
      lnk(1'b0);
      cpu(1'b0, 4'hf, 15'h0200, 32'h0);
      chk(d, 32'ha5a5_ffff);
      prog(16'h01ff, 32'h0000_0001, 1'b0, 1'b0);
      prog(16'h0200, 32'h0000_0001, 1'b0, 1'b1);
      prog(16'h03ff, 32'h0000_0001, 1'b0, 1'b1);
      prog(16'h0400, 32'h0000_0001, 1'b0, 1'b0);
      prog(16'h0805, 32'h0000_0001, 1'b0, 1'b0);
      dbg(1'b0);
      host_u.scan_reset();
      scan(otps_pkg::IR_USERCODE, 32'h0);
      chk(d, {10'h2a5, 10'h000, otps_pkg::SILICON_REV});
      scan(otps_pkg::IR_OTP_ADDR, 32'h0000_0200);
      host_u.shift(1'b0, 32, 32'h0, d);
      chk(d, 32'ha5a5_ffff);
      prog(16'h0000, 32'h0000_3000, 1'b1, 1'b0);
      boot();
      chk(protection_word, 32'ha96a_f2a2);
      prog(16'h0010, 32'h0000_0001, 1'b0, 1'b1);
      prog(16'h0000, 32'h0000_0001, 1'b1, 1'b1);
      host_u.scan_reset();
      scan(otps_pkg::IR_OTP_ADDR, 32'h0000_0200);
      host_u.shift(1'b0, 32, 32'h0, d);
      chk(d, 32'h0);
      host_u.shift(1'b1, 4, {28'h0, otps_pkg::IR_CHIP}, d);
      chk(chip_sel, 1'b1);
      test_done();
   end
endmodule // otps_top_tb
